// ===== rtl/fmu_accfile.sv
// Accumulator register file: up to three-word write, registered read
`timescale 1ns/1ps
module fmu_accfile (
    // Clock and control
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Write port
    input wire logic [2:0] wr_mask_in,
    input wire logic [3:0] wr_base_in,
    input wire logic [47:0] wr_data_in,
    // Read port
    input wire logic [3:0] rd_addr_in,
    output logic [15:0] rd_data_out
);
    typedef struct packed {
        logic [15:0][15:0] mem;
        logic [15:0] rd;
    } fmu_acc_t;
    fmu_acc_t q, d;

    // Consecutive words wrap around the file
    always_comb begin
        d = q;
        d.rd = q.mem[rd_addr_in];
        for (int i = 0; i < 3; i++) begin
            if (wr_mask_in[i]) begin
                d.mem[4'(wr_base_in + 4'(i))] = wr_data_in[16*i +: 16];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    assign rd_data_out = q.rd;
endmodule

// ===== rtl/fmu_core.sv
// Filter tap, loop close and sign fill execution unit
`timescale 1ns/1ps
module fmu_core (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Instruction issue
    input wire logic instr_valid_in,
    input wire logic [16:0] instr_in,
    input wire logic [15:0] rpt_count_in,
    input wire logic [15:0] acc_ptrs_in,
    output logic instr_ready_out,
    output logic instr_done_out,
    output logic [15:0] pc_out,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Data memory
    output logic [15:0] dmem_addr_out,
    output logic dmem_rd_out,
    input wire logic [15:0] dmem_rdata_in,
    // Program memory
    output logic [15:0] pmem_addr_out,
    output logic pmem_rd_out,
    input wire logic [15:0] pmem_rdata_in,
    // Interrupt control
    output logic irq_hold_out,
    output logic irq_service_out,
    // Accumulator read
    input wire logic [3:0] acc_rd_addr_in,
    output logic [15:0] acc_rdata_out
);
    typedef struct packed {
        fmu_pkg::fmu_state_t st;
        logic [2:0] kind;
        logic [2:0] idx;
        logic [3:0] abase;
        logic [15:0] taps;
        logic [47:0] acc;
        logic [7:0][15:0] r;
        logic [15:0] wrap_step;
        logic [15:0] loop_cnt;
        logic [15:0] rom_ptr;
        logic [15:0] mr;
        logic [15:0] loop_start;
        logic [15:0] pc;
        logic [fmu_pkg::CTL_W-1:0] ctl;
        logic coef_pend;
        logic [15:0] dmem_addr;
        logic dmem_rd;
        logic [15:0] pmem_addr;
        logic pmem_rd;
        logic ready;
        logic done;
        logic hold;
        logic svc;
        logic [15:0] rdata;
    } fmu_core_t;
    fmu_core_t q, d;

    logic [47:0] mac_sum;
    logic [2:0] acc_mask;
    logic [3:0] acc_wbase;
    logic [47:0] acc_wdata;
    logic take;
    logic [2:0] op_kind;
    logic [1:0] op_acc;
    logic [3:0] aptr;
    logic [2:0] ev;
    logic [2:0] od;

    fmu_mac u_mac (
        .sample_in(dmem_rdata_in),
        .coef_in(q.mr),
        .acc_in(q.acc),
        .narrow_in(q.kind == fmu_pkg::KIND_FIR_DD),
        .acc_out(mac_sum)
    );

    fmu_accfile u_acc (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .wr_mask_in(acc_mask),
        .wr_base_in(acc_wbase),
        .wr_data_in(acc_wdata),
        .rd_addr_in(acc_rd_addr_in),
        .rd_data_out(acc_rdata_out)
    );

    // Decode fields and the even/odd pointer pair
    always_comb begin
        take = instr_valid_in && q.ready;
        op_kind = instr_in[fmu_pkg::OP_KIND_LSB +: 3];
        op_acc = instr_in[fmu_pkg::OP_ACC_LSB +: 2];
        aptr = acc_ptrs_in[4*op_acc +: 4];
        ev = {q.idx[2:1], 1'b0};
        od = {q.idx[2:1], 1'b1};
    end

    // Next state: software access first so hardware updates win, except a returning coefficient, which a software MR write overrides
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.svc = 1'b0;
        d.dmem_rd = 1'b0;
        d.pmem_rd = 1'b0;
        d.rdata = '0;
        acc_mask = '0;
        acc_wbase = '0;
        acc_wdata = '0;
        // Coefficient returned one cycle after its read
        if (q.coef_pend) begin
            d.mr = (q.kind == fmu_pkg::KIND_XCORR_ROM) ? pmem_rdata_in : dmem_rdata_in;
            d.coef_pend = 1'b0;
        end
        if (reg_wr_in) begin
            if (!reg_addr_in[3]) begin
                d.r[reg_addr_in[2:0]] = reg_wdata_in;
            end else begin
                unique case (reg_addr_in)
                    fmu_pkg::REG_WRAP_STEP: d.wrap_step = reg_wdata_in;
                    fmu_pkg::REG_LOOP_CNT: d.loop_cnt = reg_wdata_in;
                    fmu_pkg::REG_ROM_PTR: d.rom_ptr = reg_wdata_in;
                    fmu_pkg::REG_MR: d.mr = reg_wdata_in;
                    fmu_pkg::REG_LOOP_START: d.loop_start = reg_wdata_in;
                    fmu_pkg::REG_CTRL: d.ctl = reg_wdata_in[fmu_pkg::CTL_W-1:0];
                    default: ;  // PC and state are read-only
                endcase
            end
        end
        if (reg_rd_in) begin
            if (!reg_addr_in[3]) begin
                d.rdata = q.r[reg_addr_in[2:0]];
            end else begin
                unique case (reg_addr_in)
                    fmu_pkg::REG_WRAP_STEP: d.rdata = q.wrap_step;
                    fmu_pkg::REG_LOOP_CNT: d.rdata = q.loop_cnt;
                    fmu_pkg::REG_ROM_PTR: d.rdata = q.rom_ptr;
                    fmu_pkg::REG_MR: d.rdata = q.mr;
                    fmu_pkg::REG_LOOP_START: d.rdata = q.loop_start;
                    fmu_pkg::REG_CTRL: d.rdata = 16'(q.ctl);
                    fmu_pkg::REG_PC: d.rdata = q.pc;
                    default: d.rdata = {13'h0000, q.taps == '0, q.st};
                endcase
            end
        end
        unique case (q.st)
            fmu_pkg::ST_IDLE: begin
                if (take) begin
                    d.done = 1'b1;
                    d.pc = q.pc + 16'h0001;
                    if ((instr_in & fmu_pkg::OP_FILT_MASK) == fmu_pkg::OP_FILT_VAL &&
                        op_kind != 3'h0) begin
                        // Repeat count holds taps minus two; MR already holds h[0]
                        d.done = 1'b0;
                        d.pc = q.pc;
                        d.kind = op_kind;
                        d.idx = instr_in[fmu_pkg::OP_IDX_LSB +: 3];
                        d.abase = aptr;
                        d.taps = rpt_count_in + 16'h0001;
                        d.acc = '0;
                        d.st = fmu_pkg::ST_SAMP;
                        d.dmem_rd = 1'b1;
                        d.dmem_addr = q.r[{instr_in[fmu_pkg::OP_IDX_LSB + 1 +: 2], 1'b0}];
                    end else if ((instr_in & fmu_pkg::OP_LOOP_MASK) == fmu_pkg::OP_LOOP_VAL) begin
                        // Single-cycle close; held interrupts are released here
                        d.svc = 1'b1;
                        if (!q.loop_cnt[15]) begin
                            d.loop_cnt = q.loop_cnt - (instr_in[fmu_pkg::OP_LOW_BIT] ?
                                16'h0002 : 16'h0001);
                            d.pc = q.loop_start;
                        end
                    end else if ((instr_in & fmu_pkg::OP_SFILL_MASK) == fmu_pkg::OP_SFILL_VAL) begin
                        // Runs once whatever the string count; no flag is written
                        acc_mask = 3'h1;
                        acc_wbase = aptr + fmu_pkg::ACC_STEP +
                            (instr_in[fmu_pkg::OP_LOW_BIT] ? fmu_pkg::ACC_PARTNER_OFS : 4'h0);
                        acc_wdata = {32'h0, {16{q.ctl[fmu_pkg::CTL_SIGN]}}};
                    end else if ((instr_in & fmu_pkg::OP_WFILL_MASK) == fmu_pkg::OP_WFILL_VAL) begin
                        // Premodify pointer first, then fill all sixteen bits
                        acc_mask = 3'h1;
                        acc_wbase = aptr + (instr_in[fmu_pkg::OP_LOW_BIT] ?
                            fmu_pkg::ACC_PARTNER_OFS : 4'h0);
                        if (instr_in[fmu_pkg::OP_NEXTA_LSB +: 2] == fmu_pkg::NEXTA_INC) begin
                            acc_wbase = acc_wbase + fmu_pkg::ACC_STEP;
                        end else if (instr_in[fmu_pkg::OP_NEXTA_LSB +: 2] == fmu_pkg::NEXTA_DEC) begin
                            acc_wbase = acc_wbase - fmu_pkg::ACC_STEP;
                        end
                        acc_wdata = {32'h0, {16{q.ctl[fmu_pkg::CTL_SIGN]}}};
                    end
                end
            end
            fmu_pkg::ST_SAMP: begin
                // Coefficient fetch: odd partner, or ROM pointer for the ROM kind
                d.st = fmu_pkg::ST_MAC;
                if (q.kind == fmu_pkg::KIND_XCORR_ROM) begin
                    d.pmem_rd = 1'b1;
                    d.pmem_addr = q.rom_ptr;
                    d.rom_ptr = q.rom_ptr + 16'h0001;
                end else begin
                    d.dmem_rd = 1'b1;
                    d.dmem_addr = q.r[od];
                    d.r[od] = q.r[od] + 16'h0001;
                end
            end
            fmu_pkg::ST_MAC: begin
                d.acc = mac_sum;
                d.coef_pend = 1'b1;  // Coefficient strobed this cycle lands on the bus next cycle
                if (q.ctl[fmu_pkg::CTL_WRAP]) begin
                    d.r[ev] = q.r[ev] + q.wrap_step;
                end else if (q.ctl[fmu_pkg::CTL_POSTINC]) begin
                    d.r[ev] = q.r[ev] + 16'h0001;
                end
                if (q.taps == '0) begin
                    // Final sum into three consecutive accumulators
                    acc_mask = 3'h7;
                    acc_wbase = q.abase;
                    acc_wdata = mac_sum;
                end
                if (q.kind != fmu_pkg::KIND_FIR_DD) begin
                    d.st = fmu_pkg::ST_WAIT;
                end else if (q.taps == '0) begin
                    d.st = fmu_pkg::ST_IDLE;
                    d.done = 1'b1;
                    d.pc = q.pc + 16'h0001;
                end else begin
                    d.taps = q.taps - 16'h0001;
                    d.st = fmu_pkg::ST_SAMP;
                    d.dmem_rd = 1'b1;
                    d.dmem_addr = d.r[ev];
                end
            end
            fmu_pkg::ST_WAIT: begin
                // Third cycle of a correlation tap
                if (q.taps == '0) begin
                    d.st = fmu_pkg::ST_IDLE;
                    d.done = 1'b1;
                    d.pc = q.pc + 16'h0001;
                end else begin
                    d.taps = q.taps - 16'h0001;
                    d.st = fmu_pkg::ST_SAMP;
                    d.dmem_rd = 1'b1;
                    d.dmem_addr = q.r[ev];
                end
            end
        endcase
        d.ready = (d.st == fmu_pkg::ST_IDLE);
        // Interrupts stay queued for the whole repeated filter
        d.hold = (d.st != fmu_pkg::ST_IDLE);
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            q <= '0;
            q.st <= fmu_pkg::ST_IDLE;
            q.ready <= 1'b1;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    assign instr_ready_out = q.ready;
    assign instr_done_out = q.done;
    assign pc_out = q.pc;
    assign reg_rdata_out = q.rdata;
    assign dmem_addr_out = q.dmem_addr;
    assign dmem_rd_out = q.dmem_rd;
    assign pmem_addr_out = q.pmem_addr;
    assign pmem_rd_out = q.pmem_rd;
    assign irq_hold_out = q.hold;
    assign irq_service_out = q.svc;

    // Checks assume the clock enable stays high
    logic is_filt;
    logic is_loop;
    assign is_filt = take && (instr_in & fmu_pkg::OP_FILT_MASK) == fmu_pkg::OP_FILT_VAL &&
        op_kind != 3'h0;
    assign is_loop = take && (instr_in & fmu_pkg::OP_LOOP_MASK) == fmu_pkg::OP_LOOP_VAL;

    property p_corr_len;
        @(posedge clock_in) disable iff (sys_rst_in)
        (is_filt && op_kind != fmu_pkg::KIND_FIR_DD && rpt_count_in == '0)
            |-> !instr_done_out [*7] ##1 instr_done_out;
    endproperty
    a_corr_len: assert property (p_corr_len) else $error("correlation length wrong");

    property p_fir_len;
        @(posedge clock_in) disable iff (sys_rst_in)
        (is_filt && op_kind == fmu_pkg::KIND_FIR_DD && rpt_count_in == '0)
            |-> !instr_done_out [*5] ##1 instr_done_out;
    endproperty
    a_fir_len: assert property (p_fir_len) else $error("fir length wrong");

    property p_hold;
        @(posedge clock_in) disable iff (sys_rst_in)
        is_filt |=> (irq_hold_out || instr_done_out) throughout (##[1:300] instr_done_out);
    endproperty
    a_hold: assert property (p_hold) else $error("interrupts not held");

    property p_odd_ptr;
        @(posedge clock_in) disable iff (sys_rst_in)
        (q.st == fmu_pkg::ST_MAC && q.kind != fmu_pkg::KIND_XCORR_ROM)
            |-> dmem_rd_out && dmem_addr_out == $past(q.r[od]);
    endproperty
    a_odd_ptr: assert property (p_odd_ptr) else $error("coefficient pointer wrong");

    property p_rom_ptr;
        @(posedge clock_in) disable iff (sys_rst_in)
        (q.st == fmu_pkg::ST_SAMP && q.kind == fmu_pkg::KIND_XCORR_ROM && !reg_wr_in)
            |=> pmem_rd_out && pmem_addr_out == $past(q.rom_ptr);
    endproperty
    a_rom_ptr: assert property (p_rom_ptr) else $error("rom pointer fetch wrong");

    property p_wrap;
        @(posedge clock_in) disable iff (sys_rst_in)
        (q.st == fmu_pkg::ST_MAC && q.ctl[fmu_pkg::CTL_WRAP] && !reg_wr_in)
            |=> q.r[ev] == $past(q.r[ev]) + $past(q.wrap_step);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap step not applied");

    property p_loop_br;
        @(posedge clock_in) disable iff (sys_rst_in)
        (is_loop && !q.loop_cnt[15] && !reg_wr_in) |=> pc_out == $past(q.loop_start) &&
            q.loop_cnt == $past(q.loop_cnt) - ($past(instr_in[0]) ? 16'h0002 : 16'h0001);
    endproperty
    a_loop_br: assert property (p_loop_br) else $error("loop branch wrong");

    property p_loop_fall;
        @(posedge clock_in) disable iff (sys_rst_in)
        (is_loop && q.loop_cnt[15]) |=> pc_out == $past(q.pc) + 16'h0001 && instr_ready_out;
    endproperty
    a_loop_fall: assert property (p_loop_fall) else $error("loop fall through wrong");

    property p_loop_svc;
        @(posedge clock_in) disable iff (sys_rst_in)
        is_loop |=> irq_service_out && instr_done_out ##1 (irq_service_out == $past(is_loop));
    endproperty
    a_loop_svc: assert property (p_loop_svc) else $error("loop service wrong");

    c_corr: cover property (@(posedge clock_in) is_filt && op_kind == fmu_pkg::KIND_XCORR_DD);
    c_fir: cover property (@(posedge clock_in) is_filt && op_kind == fmu_pkg::KIND_FIR_DD);
    c_loop: cover property (@(posedge clock_in) is_loop && !q.loop_cnt[15]);
endmodule

// ===== rtl/fmu_mac.sv
// Signed 16x16 multiply-accumulate for filter taps
`timescale 1ns/1ps
module fmu_mac (
    // Operands
    input wire logic [15:0] sample_in,
    input wire logic [15:0] coef_in,
    input wire logic [47:0] acc_in,
    input wire logic narrow_in,
    // Result
    output logic [47:0] acc_out
);
    logic signed [31:0] prod;
    logic [47:0] wide;
    logic [31:0] low;

    // Narrow mode wraps at 32 bits, then sign-extends for the triple write
    always_comb begin
        prod = $signed(sample_in) * $signed(coef_in);
        wide = acc_in + {{16{prod[31]}}, prod};
        low = acc_in[31:0] + prod;
        acc_out = narrow_in ? {{16{low[31]}}, low} : wide;
    end
endmodule

// ===== rtl/fmu_pkg.sv
// Shared constants, opcode patterns and register map of the filter/loop/sign unit
package fmu_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned AW = 4;
    localparam int unsigned OPW = 17;
    // Instruction patterns and masks
    localparam logic [16:0] OP_FILT_MASK = 17'h1fc03;
    localparam logic [16:0] OP_FILT_VAL = 17'h1d003;
    localparam logic [16:0] OP_WFILL_MASK = 17'h1f0fe;
    localparam logic [16:0] OP_WFILL_VAL = 17'h1c078;
    localparam logic [16:0] OP_SFILL_MASK = 17'h1fcfe;
    localparam logic [16:0] OP_SFILL_VAL = 17'h1cc78;
    localparam logic [16:0] OP_LOOP_MASK = 17'h1fffe;
    localparam logic [16:0] OP_LOOP_VAL = 17'h1fe10;
    // Field positions
    localparam int unsigned OP_NEXTA_LSB = 10;
    localparam int unsigned OP_ACC_LSB = 8;
    localparam int unsigned OP_KIND_LSB = 5;
    localparam int unsigned OP_IDX_LSB = 2;
    localparam int unsigned OP_LOW_BIT = 0;
    // Filter kinds in bits 7..5
    localparam logic [2:0] KIND_XCORR_DD = 3'h6;
    localparam logic [2:0] KIND_XCORR_ROM = 3'h4;
    localparam logic [2:0] KIND_FIR_DD = 3'h2;
    // Accumulator pointer premodification codes
    localparam logic [1:0] NEXTA_INC = 2'h1;
    localparam logic [1:0] NEXTA_DEC = 2'h2;
    localparam logic [3:0] ACC_PARTNER_OFS = 4'h1;
    localparam logic [3:0] ACC_STEP = 4'h1;
    // Register map
    localparam logic [3:0] REG_WRAP_STEP = 4'h8;
    localparam logic [3:0] REG_LOOP_CNT = 4'h9;
    localparam logic [3:0] REG_ROM_PTR = 4'ha;
    localparam logic [3:0] REG_MR = 4'hb;
    localparam logic [3:0] REG_LOOP_START = 4'hc;
    localparam logic [3:0] REG_CTRL = 4'hd;
    localparam logic [3:0] REG_PC = 4'he;
    localparam logic [3:0] REG_STATE = 4'hf;
    // Control register bits
    localparam int unsigned CTL_WRAP = 0;
    localparam int unsigned CTL_SIGN = 1;
    localparam int unsigned CTL_POSTINC = 2;
    localparam int unsigned CTL_W = 3;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMP, ST_MAC, ST_WAIT} fmu_state_t;
endpackage

// ===== tb/fmu_core_test.sv
// Self-checking bench for the filter, loop close and sign fill unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fmu_core_test;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [16:0] instr_in = 17'h0;
    logic [15:0] rpt_count_in = 16'h0;
    logic [15:0] acc_ptrs_in = 16'hc840;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] dmem_rdata_in = 16'h0;
    logic [15:0] pmem_rdata_in = 16'h0;
    logic [3:0] acc_rd_addr_in = 4'h0;
    logic instr_ready_out, instr_done_out, dmem_rd_out, pmem_rd_out;
    logic irq_hold_out, irq_service_out;
    logic [15:0] pc_out, reg_rdata_out, dmem_addr_out, pmem_addr_out, acc_rdata_out;
    logic [15:0] dmem [16];
    logic [15:0] pmem [16];
    logic hold_seen, svc_seen;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    fmu_core u_fmu_core (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .rpt_count_in(rpt_count_in),
        .acc_ptrs_in(acc_ptrs_in), .instr_ready_out(instr_ready_out),
        .instr_done_out(instr_done_out), .pc_out(pc_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .dmem_addr_out(dmem_addr_out), .dmem_rd_out(dmem_rd_out),
        .dmem_rdata_in(dmem_rdata_in), .pmem_addr_out(pmem_addr_out), .pmem_rd_out(pmem_rd_out),
        .pmem_rdata_in(pmem_rdata_in), .irq_hold_out(irq_hold_out),
        .irq_service_out(irq_service_out), .acc_rd_addr_in(acc_rd_addr_in),
        .acc_rdata_out(acc_rdata_out));

    // 100 MHz clock
    always #5 clock_in = ~clock_in;

    // Memories answer one cycle after the strobe; idle data keeps toggling so stale reads show
    always @(posedge clock_in) begin
        dmem_rdata_in <= dmem_rd_out ? dmem[dmem_addr_out[3:0]] : ~dmem_rdata_in;
        pmem_rdata_in <= pmem_rd_out ? pmem[pmem_addr_out[3:0]] : ~pmem_rdata_in;
    end

    // Hang guard: the whole sequence needs under 150 cycles
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        `CHK(reg_rdata_out, exp)
    endtask

    task automatic acc_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        acc_rd_addr_in <= a;
        @(posedge clock_in);
        #1;
        `CHK(acc_rdata_out, exp)
    endtask

    // Offer one instruction, count cycles from the take edge to the done pulse
    task automatic issue(input logic [16:0] op, input logic [15:0] repeat_prefix, input int lat,
            input logic [15:0] npc, input logic hold);
        int n;
        n = 1;
        hold_seen = 1'b0;
        svc_seen = 1'b0;
        @(posedge clock_in);
        instr_valid_in <= 1'b1;
        instr_in <= op;
        rpt_count_in <= repeat_prefix;
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        #1;
        while (instr_done_out !== 1'b1 && n < 100) begin
            hold_seen = hold_seen | (irq_hold_out === 1'b1);
            svc_seen = svc_seen | (irq_service_out === 1'b1);
            @(posedge clock_in);
            #1;
            n++;
        end
        svc_seen = svc_seen | (irq_service_out === 1'b1);
        `CHK(n, lat)
        `CHK(pc_out, npc)
        `CHK(hold_seen, hold)
    endtask

    function automatic logic [16:0] fop(input logic [1:0] an, input logic [2:0] kind,
            input logic [2:0] rx);
        return fmu_pkg::OP_FILT_VAL | {7'h0, an, kind, rx, 2'h0};
    endfunction

    initial begin
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        `CHK(instr_ready_out, 1'b1)
        `CHK(pc_out, 16'h0000)
        reg_chk(fmu_pkg::REG_CTRL, 16'h0000);
        reg_chk(fmu_pkg::REG_LOOP_CNT, 16'h0000);
        end_test("reset");
        // Register port, read-only program counter
        reg_wr(4'h0, 16'h1234);
        reg_chk(4'h0, 16'h1234);
        reg_wr(fmu_pkg::REG_PC, 16'h00ff);
        reg_chk(fmu_pkg::REG_PC, 16'h0000);
        // Clock enable low: the write must not land
        @(posedge clock_in);
        clk_en_in <= 1'b0;
        reg_wr(4'h0, 16'h5678);
        clk_en_in <= 1'b1;
        reg_chk(4'h0, 16'h1234);
        end_test("registers");
        // Sign fills: A0 ptr 0, A2 ptr 8, A3 ptr c
        reg_wr(fmu_pkg::REG_CTRL, 16'h0006);
        issue(fmu_pkg::OP_WFILL_VAL | 17'h00001, 16'h0, 1, 16'h0001, 1'b0);
        acc_chk(4'h1, 16'hffff);
        acc_chk(4'h0, 16'h0000);
        issue(fmu_pkg::OP_WFILL_VAL | 17'h00700, 16'h0, 1, 16'h0002, 1'b0);
        acc_chk(4'hd, 16'hffff);
        issue(fmu_pkg::OP_SFILL_VAL | 17'h00200, 16'h0, 1, 16'h0003, 1'b0);
        acc_chk(4'h9, 16'hffff);
        acc_chk(4'h8, 16'h0000);
        reg_wr(fmu_pkg::REG_CTRL, 16'h0004);
        issue(fmu_pkg::OP_WFILL_VAL | 17'h00001, 16'h0, 1, 16'h0004, 1'b0);
        acc_chk(4'h1, 16'h0000);
        end_test("sign_fill");
        // Loop close: branch with step one, branch with step two, then fall through
        reg_wr(fmu_pkg::REG_LOOP_START, 16'h0040);
        reg_wr(fmu_pkg::REG_LOOP_CNT, 16'h0001);
        issue(fmu_pkg::OP_LOOP_VAL, 16'h0, 1, 16'h0040, 1'b0);
        `CHK(svc_seen, 1'b1)
        reg_chk(fmu_pkg::REG_LOOP_CNT, 16'h0000);
        issue(fmu_pkg::OP_LOOP_VAL | 17'h1, 16'h0, 1, 16'h0040, 1'b0);
        reg_chk(fmu_pkg::REG_LOOP_CNT, 16'hfffe);
        issue(fmu_pkg::OP_LOOP_VAL, 16'h0, 1, 16'h0041, 1'b0);
        reg_chk(fmu_pkg::REG_LOOP_CNT, 16'hfffe);
        end_test("loop_close");
        // Two-tap correlations: 3*5 + (-2)*9 = -3 across three accumulators
        dmem[0] = 16'h0005;
        dmem[1] = 16'h0009;
        dmem[8] = 16'hfffe;
        pmem[8] = 16'hfffe;
        reg_wr(4'h2, 16'h0000);
        reg_wr(4'h3, 16'h0008);
        reg_wr(fmu_pkg::REG_MR, 16'h0003);
        issue(fop(2'h1, fmu_pkg::KIND_XCORR_DD, 3'h2), 16'h0, 7, 16'h0042, 1'b1);
        acc_chk(4'h4, 16'hfffd);
        acc_chk(4'h5, 16'hffff);
        acc_chk(4'h6, 16'hffff);
        reg_chk(fmu_pkg::REG_CTRL, 16'h0004);
        reg_chk(4'h2, 16'h0002);
        reg_wr(4'h4, 16'h0000);
        reg_wr(fmu_pkg::REG_MR, 16'h0003);
        reg_wr(fmu_pkg::REG_ROM_PTR, 16'h0008);
        issue(fop(2'h3, fmu_pkg::KIND_XCORR_ROM, 3'h4), 16'h0, 7, 16'h0043, 1'b1);
        acc_chk(4'hc, 16'hfffd);
        acc_chk(4'he, 16'hffff);
        end_test("correlation");
        // Wrap step on the sample pointer, tap timing for longer repeats, unhandled kind
        reg_wr(fmu_pkg::REG_WRAP_STEP, 16'h0003);
        reg_wr(fmu_pkg::REG_CTRL, 16'h0001);
        issue(fop(2'h2, fmu_pkg::KIND_FIR_DD, 3'h0), 16'h1, 7, 16'h0044, 1'b1);
        reg_chk(4'h0, 16'h123d);
        reg_chk(4'h1, 16'h0003);
        issue(fop(2'h1, fmu_pkg::KIND_XCORR_DD, 3'h2), 16'h2, 13, 16'h0045, 1'b1);
        issue(fop(2'h1, 3'h0, 3'h2), 16'h2, 1, 16'h0046, 1'b0);
        end_test("tap_timing");
        wrap_up();
    end
endmodule
